//--- hdl/pipe_pkg.sv
// What this block does
// - Status bits 15:12 hold fault; raise interrupt
// - Bits 11:8 take rcode; unified write loads 1111
// - Bits 7:4 keep ack received for request
// - Bits 3:0 keep ack sent for response
// - Start bit clears the whole status word
// - On fault stop requests, latch codes, interrupt
// - Writing one to init bit clears status
// - Fault codes one to eight as listed
// - Bad tcode: 2 with dir 0, 6/7 with 1
// - Simultaneous faults report the lowest code
// - Busy acknowledge retransmits the same request
// - Bits 27:20 retry wait in 125 us units
// - Bits 19:16 retry limit, zero disables retries
// - Split response later than bits 15:0 ticks faults
// - Retry and timeout word resets to 800
// - Flush bits always writable, flags need override
// - Receive flags at bits 31,30,29,27,26
// - Bit 28 marks first or last packet quadlet
// - Transmit flags at bits 23 down to 19
// - Bits 15 and 13 flush FIFOs, self clear
// - Status at 38h read only, resets zero
// - Start bit 0 self clears on end or fault
// - Init bit 2 returns pipe to initial state
package pipe_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h34;
   localparam logic [7:0] ADDR_STATUS = 8'h38;
   localparam logic [7:0] ADDR_RETRY_TIMEOUT = 8'h3C;
   localparam logic [7:0] ADDR_FIFO_STATUS = 8'h40;

   // Reset values
   localparam logic [31:0] RETRY_TIMEOUT_RESET = 32'h00000320;
   localparam logic [31:0] FIFO_STATUS_RESET = 32'h04280000;

   // Field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_INIT_BIT = 2;
   localparam int ST_FAULT_LSB = 12;
   localparam int ST_RCODE_LSB = 8;
   localparam int ST_ACK_IN_LSB = 4;
   localparam int ST_ACK_OUT_LSB = 0;
   localparam int CFG_INTERVAL_LSB = 20;
   localparam int CFG_LIMIT_LSB = 16;
   localparam int CFG_SPLIT_LSB = 0;
   localparam int FS_RX_FULL = 31;
   localparam int FS_RX_AFULL = 30;
   localparam int FS_RX_4TH = 29;
   localparam int FS_RX_EDGE = 28;
   localparam int FS_RX_AEMPTY = 27;
   localparam int FS_RX_EMPTY = 26;
   localparam int FS_TX_FULL = 23;
   localparam int FS_TX_AFULL = 22;
   localparam int FS_TX_4AVAIL = 21;
   localparam int FS_TX_AEMPTY = 20;
   localparam int FS_TX_EMPTY = 19;
   localparam int FS_TX_FLUSH = 15;
   localparam int FS_RX_FLUSH = 13;
   localparam int FS_OVERRIDE = 0;
   // Flag bits that software may write only under override
   localparam logic [31:0] FS_FLAG_MASK = 32'hFCF80001;

   // Codes on the serial bus
   localparam logic [3:0] RCODE_UNIFIED = 4'hF;
   localparam logic [3:0] ACK_COMPLETE = 4'h1;
   localparam logic [3:0] ACK_PENDING = 4'h2;
   localparam logic [3:0] ACK_BUSY_X = 4'h4;
   localparam logic [3:0] ACK_BUSY_B = 4'h6;
   localparam logic [3:0] TCODE_BAD_D0 = 4'h2;
   localparam logic [3:0] TCODE_BAD_D1A = 4'h6;
   localparam logic [3:0] TCODE_BAD_D1B = 4'h7;

   // Fault codes
   localparam int FAULT_NUM = 8;
   localparam logic [3:0] FAULT_ACK_RECEIVED = 4'h1;
   localparam logic [3:0] FAULT_ACK_SENT = 4'h2;
   localparam logic [3:0] FAULT_SPLIT_TIMEOUT = 4'h3;
   localparam logic [3:0] FAULT_BUSY_TIMEOUT = 4'h4;
   localparam logic [3:0] FAULT_BUS_RESET = 4'h5;
   localparam logic [3:0] FAULT_BAD_RCODE = 4'h6;
   localparam logic [3:0] FAULT_WRONG_NODE = 4'h7;
   localparam logic [3:0] FAULT_BAD_TCODE = 4'h8;

   // Time base
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_NS = 125000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT_ACK = 2'b01,
      ST_RETRY_WAIT = 2'b10,
      ST_SPLIT_WAIT = 2'b11
   } pipe_state_t;

endpackage

//--- hdl/pipe_event_if.sv
`timescale 1ns/10ps
interface pipe_event_if;
   logic tick;
   logic [pipe_pkg::FAULT_NUM-1:0] fault_vec;
   logic [3:0] fault_code;
   logic fault_any;

   modport timebase (output tick);
   modport encoder (input fault_vec, output fault_code, output fault_any);
   modport core (input tick, input fault_code, input fault_any, output fault_vec);
endinterface

//--- hdl/pipe_tick_gen.sv
`timescale 1ns/10ps
module pipe_tick_gen #(
   parameter int TICK_CYCLES = pipe_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   pipe_event_if.timebase ev
);
   logic [15:0] count_reg;
   logic tick_reg;

   // Free running 125 us time base shared by all timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end else if (count_reg == 16'(TICK_CYCLES - 1)) begin
         count_reg <= 16'h0000;
         tick_reg <= 1'b1;
      end else begin
         count_reg <= count_reg + 16'h0001;
         tick_reg <= 1'b0;
      end
   end

   assign ev.tick = tick_reg;
endmodule

//--- hdl/pipe_fault_encoder.sv
`timescale 1ns/10ps
module pipe_fault_encoder (
   pipe_event_if.encoder ev
);
   // Lowest numbered fault wins when several arrive together
   always_comb begin
      ev.fault_code = 4'h0;
      ev.fault_any = |ev.fault_vec;
      for (int i = pipe_pkg::FAULT_NUM - 1; i >= 0; i--) begin
         if (ev.fault_vec[i]) begin
            ev.fault_code = 4'(i + 1);
         end
      end
   end
endmodule

//--- hdl/pipe_status_retry.sv
`timescale 1ns/10ps
module pipe_status_retry #(
   parameter int TICK_CYCLES = pipe_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pipe engine events
   input wire logic pipe_direction,
   input wire logic req_sent,
   input wire logic [3:0] req_ack,
   input wire logic resp_rcvd,
   input wire logic [3:0] resp_rcode,
   input wire logic [3:0] resp_tcode,
   input wire logic resp_src_ok,
   input wire logic [3:0] resp_ack_sent,
   input wire logic unified_write_done,
   input wire logic bus_reset,
   input wire logic transfer_done,
   // Live FIFO flags
   input wire logic rx_full,
   input wire logic rx_almost_full,
   input wire logic rx_four_stored,
   input wire logic rx_packet_edge_flag,
   input wire logic rx_one_stored,
   input wire logic rx_empty,
   input wire logic tx_full,
   input wire logic tx_room_one,
   input wire logic tx_room_four,
   input wire logic tx_one_left,
   input wire logic tx_empty,
   // Pipe control outputs
   output logic pipe_active,
   output logic request_enable,
   output logic retransmit,
   output logic pipe_fault_interrupt,
   output logic tx_fifo_flush,
   output logic rx_fifo_flush
);
   pipe_event_if ev ();

   pipe_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .ev(ev.timebase)
   );

   pipe_fault_encoder u_enc (
      .ev(ev.encoder)
   );

   logic [31:0] status_reg;
   logic [31:0] cfg_reg;
   logic [31:0] fifo_shadow_reg;
   logic start_reg;
   logic request_enable_reg;
   logic retransmit_reg;
   logic fault_irq_reg;
   logic tx_flush_reg;
   logic rx_flush_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   pipe_pkg::pipe_state_t state_reg;
   pipe_pkg::pipe_state_t state_next;
   logic [15:0] wait_reg;
   logic [3:0] retries_reg;

   logic wr_en;
   logic rd_en;
   logic start_wr;
   logic init_wr;
   logic record_fault;
   logic req_busy;
   logic req_error;
   logic busy_exhausted;
   logic retry_due;
   logic split_expired;
   logic [7:0] interval;
   logic [3:0] limit;
   logic [15:0] split_limit;
   logic [31:0] fifo_live;
   logic [31:0] fifo_view;

   // Transaction code check against the transfer direction
   function automatic logic tcode_bad(input logic [3:0] tcode, input logic dir);
      if (!dir) begin
         tcode_bad = (tcode == pipe_pkg::TCODE_BAD_D0);
      end else begin
         tcode_bad = (tcode == pipe_pkg::TCODE_BAD_D1A) || (tcode == pipe_pkg::TCODE_BAD_D1B);
      end
   endfunction

   // Busy acknowledge family
   function automatic logic ack_is_busy(input logic [3:0] ack);
      ack_is_busy = (ack >= pipe_pkg::ACK_BUSY_X) && (ack <= pipe_pkg::ACK_BUSY_B);
   endfunction

   // Writes decoded on the edge that completes them, reads one edge earlier
   assign wr_en = psel && penable && pready_reg && pwrite;
   assign rd_en = psel && penable && !pready_reg;
   assign start_wr = wr_en && (paddr == pipe_pkg::ADDR_CONTROL) && pwdata[pipe_pkg::CTRL_START_BIT];
   assign init_wr = wr_en && (paddr == pipe_pkg::ADDR_CONTROL) && pwdata[pipe_pkg::CTRL_INIT_BIT];

   // Configuration fields
   assign interval = cfg_reg[pipe_pkg::CFG_INTERVAL_LSB +: 8];
   assign limit = cfg_reg[pipe_pkg::CFG_LIMIT_LSB +: 4];
   assign split_limit = cfg_reg[pipe_pkg::CFG_SPLIT_LSB +: 16];

   // Acknowledge classification for the request just issued
   assign req_busy = req_sent && ack_is_busy(req_ack);
   assign req_error = req_sent && !ack_is_busy(req_ack) && (req_ack != pipe_pkg::ACK_COMPLETE)
                      && (req_ack != pipe_pkg::ACK_PENDING);
   assign busy_exhausted = (state_reg == pipe_pkg::ST_WAIT_ACK) && req_busy
                           && ((limit == 4'h0) || (retries_reg >= limit));
   assign retry_due = (state_reg == pipe_pkg::ST_RETRY_WAIT)
                      && ((interval == 8'h00) || (ev.tick && (wait_reg >= 16'(interval) - 16'h0001)));
   assign split_expired = (state_reg == pipe_pkg::ST_SPLIT_WAIT) && !resp_rcvd && ev.tick
                          && (wait_reg >= split_limit);

   // Fault sources, bit n stands for code n+1
   always_comb begin
      ev.fault_vec = '0;
      if (state_reg != pipe_pkg::ST_IDLE) begin
         ev.fault_vec[pipe_pkg::FAULT_ACK_RECEIVED - 1] = req_error;
         ev.fault_vec[pipe_pkg::FAULT_ACK_SENT - 1] = resp_rcvd && (resp_ack_sent != pipe_pkg::ACK_COMPLETE);
         ev.fault_vec[pipe_pkg::FAULT_SPLIT_TIMEOUT - 1] = split_expired;
         ev.fault_vec[pipe_pkg::FAULT_BUSY_TIMEOUT - 1] = busy_exhausted;
         ev.fault_vec[pipe_pkg::FAULT_BUS_RESET - 1] = bus_reset;
         ev.fault_vec[pipe_pkg::FAULT_BAD_RCODE - 1] = resp_rcvd && (resp_rcode != 4'h0);
         ev.fault_vec[pipe_pkg::FAULT_WRONG_NODE - 1] = resp_rcvd && !resp_src_ok;
         ev.fault_vec[pipe_pkg::FAULT_BAD_TCODE - 1] = resp_rcvd && tcode_bad(resp_tcode, pipe_direction);
      end
   end

   assign record_fault = ev.fault_any && !start_wr && !init_wr;

   // Transfer sequencing: acks, busy retries, split waits
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pipe_pkg::ST_IDLE: begin
            if (start_wr) begin
               state_next = pipe_pkg::ST_WAIT_ACK;
            end
         end
         pipe_pkg::ST_WAIT_ACK: begin
            if (req_busy && !busy_exhausted) begin
               state_next = pipe_pkg::ST_RETRY_WAIT;
            end else if (req_sent && (req_ack == pipe_pkg::ACK_PENDING)) begin
               state_next = pipe_pkg::ST_SPLIT_WAIT;
            end
         end
         pipe_pkg::ST_RETRY_WAIT: begin
            if (retry_due) begin
               state_next = pipe_pkg::ST_WAIT_ACK;
            end
         end
         pipe_pkg::ST_SPLIT_WAIT: begin
            if (resp_rcvd) begin
               state_next = pipe_pkg::ST_WAIT_ACK;
            end
         end
      endcase
      if (init_wr || ev.fault_any || transfer_done) begin
         state_next = pipe_pkg::ST_IDLE;
      end
      if (start_wr && !init_wr) begin
         state_next = pipe_pkg::ST_WAIT_ACK;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= pipe_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Wait counter in ticks, restarted on each new wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_reg <= 16'h0000;
      end else if (state_next != state_reg) begin
         wait_reg <= 16'h0000;
      end else if (ev.tick && (wait_reg != 16'hFFFF)) begin
         wait_reg <= wait_reg + 16'h0001;
      end
   end

   // Retries spent on the current request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retries_reg <= 4'h0;
      end else if (start_wr || init_wr || (req_sent && !ack_is_busy(req_ack))) begin
         retries_reg <= 4'h0;
      end else if (retry_due) begin
         retries_reg <= retries_reg + 4'h1;
      end
   end

   // Retransmit strobe toward the packet builder
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retransmit_reg <= 1'b0;
      end else begin
         retransmit_reg <= retry_due && !ev.fault_any && !init_wr;
      end
   end

   // Start bit and request permission
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_reg <= 1'b0;
         request_enable_reg <= 1'b0;
      end else if (init_wr) begin
         start_reg <= 1'b0;
         request_enable_reg <= 1'b0;
      end else if (start_wr) begin
         start_reg <= 1'b1;
         request_enable_reg <= 1'b1;
      end else if (ev.fault_any || transfer_done) begin
         start_reg <= 1'b0;
         request_enable_reg <= 1'b0;
      end
   end

   // Status word: fault, rcode and both acknowledge codes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 32'h00000000;
      end else if (init_wr || start_wr) begin
         status_reg <= 32'h00000000;
      end else if (state_reg != pipe_pkg::ST_IDLE) begin
         if (req_sent) begin
            status_reg[pipe_pkg::ST_ACK_IN_LSB +: 4] <= req_ack;
         end
         if (resp_rcvd) begin
            status_reg[pipe_pkg::ST_RCODE_LSB +: 4] <= resp_rcode;
            status_reg[pipe_pkg::ST_ACK_OUT_LSB +: 4] <= resp_ack_sent;
         end else if (unified_write_done) begin
            status_reg[pipe_pkg::ST_RCODE_LSB +: 4] <= pipe_pkg::RCODE_UNIFIED;
         end
         if (record_fault) begin
            status_reg[pipe_pkg::ST_FAULT_LSB +: 4] <= ev.fault_code;
         end
      end
   end

   // Fault interrupt pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_irq_reg <= 1'b0;
      end else begin
         fault_irq_reg <= record_fault && (state_reg != pipe_pkg::ST_IDLE);
      end
   end

   // Retry and timeout configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= pipe_pkg::RETRY_TIMEOUT_RESET;
      end else if (wr_en && (paddr == pipe_pkg::ADDR_RETRY_TIMEOUT)) begin
         cfg_reg <= pwdata;
      end
   end

   // Software copy of FIFO flags, written only under override
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_shadow_reg <= pipe_pkg::FIFO_STATUS_RESET;
      end else if (wr_en && (paddr == pipe_pkg::ADDR_FIFO_STATUS)) begin
         if (fifo_shadow_reg[pipe_pkg::FS_OVERRIDE]) begin
            fifo_shadow_reg <= pwdata & pipe_pkg::FS_FLAG_MASK;
         end else begin
            fifo_shadow_reg[pipe_pkg::FS_OVERRIDE] <= pwdata[pipe_pkg::FS_OVERRIDE];
         end
      end
   end

   // Flush strobes, one cycle each, then read back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_flush_reg <= 1'b0;
         rx_flush_reg <= 1'b0;
      end else begin
         tx_flush_reg <= wr_en && (paddr == pipe_pkg::ADDR_FIFO_STATUS) && pwdata[pipe_pkg::FS_TX_FLUSH];
         rx_flush_reg <= wr_en && (paddr == pipe_pkg::ADDR_FIFO_STATUS) && pwdata[pipe_pkg::FS_RX_FLUSH];
      end
   end

   // Live flag word
   always_comb begin
      fifo_live = 32'h00000000;
      fifo_live[pipe_pkg::FS_RX_FULL] = rx_full;
      fifo_live[pipe_pkg::FS_RX_AFULL] = rx_almost_full;
      fifo_live[pipe_pkg::FS_RX_4TH] = rx_four_stored;
      fifo_live[pipe_pkg::FS_RX_EDGE] = rx_packet_edge_flag;
      fifo_live[pipe_pkg::FS_RX_AEMPTY] = rx_one_stored;
      fifo_live[pipe_pkg::FS_RX_EMPTY] = rx_empty;
      fifo_live[pipe_pkg::FS_TX_FULL] = tx_full;
      fifo_live[pipe_pkg::FS_TX_AFULL] = tx_room_one;
      fifo_live[pipe_pkg::FS_TX_4AVAIL] = tx_room_four;
      fifo_live[pipe_pkg::FS_TX_AEMPTY] = tx_one_left;
      fifo_live[pipe_pkg::FS_TX_EMPTY] = tx_empty;
   end

   assign fifo_view = fifo_shadow_reg[pipe_pkg::FS_OVERRIDE] ? fifo_shadow_reg
                      : (fifo_live | (fifo_shadow_reg & 32'h00000001));

   // APB answer: one wait cycle, read data registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= rd_en;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         if (rd_en) begin
            unique case (paddr)
               pipe_pkg::ADDR_CONTROL: prdata_reg <= {31'h00000000, start_reg};
               pipe_pkg::ADDR_STATUS: prdata_reg <= status_reg;
               pipe_pkg::ADDR_RETRY_TIMEOUT: prdata_reg <= cfg_reg;
               pipe_pkg::ADDR_FIFO_STATUS: prdata_reg <= fifo_view;
               default: pslverr_reg <= 1'b1;
            endcase
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pipe_active = start_reg;
   assign request_enable = request_enable_reg;
   assign retransmit = retransmit_reg;
   assign pipe_fault_interrupt = fault_irq_reg;
   assign tx_fifo_flush = tx_flush_reg;
   assign rx_fifo_flush = rx_flush_reg;
endmodule

//--- test/pipe_status_retry_assertions.sv
`timescale 1ns/10ps
module pipe_status_retry_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic req_sent,
   input wire logic [3:0] req_ack,
   input wire logic resp_rcvd,
   input wire logic bus_reset,
   input wire logic transfer_done,
   input wire logic pipe_active,
   input wire logic request_enable,
   input wire logic retransmit,
   input wire logic pipe_fault_interrupt,
   input wire logic tx_fifo_flush,
   input wire logic rx_fifo_flush
);
   logic wr_done;
   logic ctl_wr;
   logic fs_wr;
   logic [31:0] cfg_reg;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed APB writes, by target
   assign wr_done = psel && penable && pready && pwrite && !pslverr;
   assign ctl_wr = wr_done && paddr == pipe_pkg::ADDR_CONTROL;
   assign fs_wr = wr_done && paddr == pipe_pkg::ADDR_FIFO_STATUS;
   // Shadow of the retry and timeout word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= pipe_pkg::RETRY_TIMEOUT_RESET;
      end else if (wr_done && paddr == pipe_pkg::ADDR_RETRY_TIMEOUT) begin
         cfg_reg <= pwdata;
      end
   end
   a_fault_stops_pipe: assert property (pipe_fault_interrupt |-> !pipe_active && !request_enable)
      else $error("pipe runs on after fault");
   a_irq_one_cycle: assert property (pipe_fault_interrupt |=> !pipe_fault_interrupt)
      else $error("fault interrupt too long");
   a_error_ack_fault: assert property (pipe_active && req_sent && req_ack == 4'hD |=> pipe_fault_interrupt)
      else $error("error ack not reported");
   a_bus_reset_fault: assert property (pipe_active && bus_reset && !ctl_wr |=> pipe_fault_interrupt)
      else $error("bus reset not reported");
   a_idle_ignores: assert property (!pipe_active && !ctl_wr && (req_sent || resp_rcvd || bus_reset)
      |=> !pipe_fault_interrupt)
      else $error("fault while idle");
   a_busy_no_retry: assert property (pipe_active && req_sent && req_ack == 4'h4 && cfg_reg[19:16] == 4'h0
      |=> pipe_fault_interrupt && !retransmit)
      else $error("busy with zero limit not faulted");
   a_retry_now: assert property (retransmit && cfg_reg[27:20] == 8'h00
      |-> $past(req_sent, 2) && $past(req_ack, 2) >= 4'h4 && $past(req_ack, 2) <= 4'h6)
      else $error("immediate retry mistimed");
   a_start_active: assert property (ctl_wr && pwdata[0] |=> pipe_active)
      else $error("start did not activate");
   a_done_clears: assert property (pipe_active && transfer_done && !ctl_wr |=> !pipe_active)
      else $error("start bit kept after completion");
   a_tx_flush: assert property (fs_wr && pwdata[15] |=> tx_fifo_flush ##1 !tx_fifo_flush)
      else $error("tx flush pulse wrong");
   a_rx_flush: assert property (fs_wr && pwdata[13] |=> rx_fifo_flush ##1 !rx_fifo_flush)
      else $error("rx flush pulse wrong");
   c_fault: cover property (pipe_fault_interrupt);
   c_retry: cover property (retransmit);
   c_flush: cover property (tx_fifo_flush && rx_fifo_flush);
endmodule
bind pipe_status_retry pipe_status_retry_assertions u_assertions (.*);

//--- test/pipe_remote_model.sv
`timescale 1ns/10ps
module pipe_remote_model (
   input wire logic pclk,
   output logic req_sent,
   output logic [3:0] req_ack,
   output logic resp_rcvd,
   output logic [3:0] resp_rcode,
   output logic [3:0] resp_tcode,
   output logic resp_src_ok,
   output logic [3:0] resp_ack_sent,
   output logic [2:0] pipe_events,
   output logic [10:0] fifo_flags
);
   // Quiet bus, both FIFOs empty
   initial begin
      {req_sent, req_ack, resp_rcvd, resp_rcode, resp_tcode, resp_src_ok, resp_ack_sent, pipe_events, fifo_flags} =
         {1'b0, 4'hA, 1'b0, 13'h0A5A, 3'b000, 11'h025};
   end
   // Ack for one request; code inverted once it is no longer valid
   task automatic ack_req(input logic [3:0] a);
      @(posedge pclk);
      req_sent <= 1'b1;
      req_ack <= a;
      @(posedge pclk);
      req_sent <= 1'b0;
      req_ack <= ~a;
   endtask
   // Response packet after d idle cycles
   task automatic respond(input int d, input logic [3:0] rc, tc, input logic src, input logic [3:0] ao);
      repeat (d) @(posedge pclk);
      resp_rcvd <= 1'b1;
      {resp_rcode, resp_tcode, resp_src_ok, resp_ack_sent} <= {rc, tc, src, ao};
      @(posedge pclk);
      resp_rcvd <= 1'b0;
      {resp_rcode, resp_tcode, resp_src_ok, resp_ack_sent} <= ~{rc, tc, src, ao};
   endtask
   // One-cycle link event
   task automatic pulse(input logic [2:0] v);
      @(posedge pclk);
      pipe_events <= v;
      @(posedge pclk);
      pipe_events <= 3'b000;
   endtask
   task automatic set_flags(input logic [10:0] f);
      @(posedge pclk);
      fifo_flags <= f;
   endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("wrong value at %0t: got %h want %h", $time, got, exp); end end
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pipe_direction;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, err, req_sent, resp_rcvd, resp_src_ok, unified_write_done, bus_reset, transfer_done;
   logic [3:0] req_ack, resp_rcode, resp_tcode, resp_ack_sent;
   logic rx_full, rx_almost_full, rx_four_stored, rx_packet_edge_flag, rx_one_stored, rx_empty;
   logic tx_full, tx_room_one, tx_room_four, tx_one_left, tx_empty;
   logic pipe_active, request_enable, retransmit, pipe_fault_interrupt, tx_fifo_flush, rx_fifo_flush;
   logic [2:0] pipe_events;
   logic [10:0] fifo_flags;
   int bad_count = 0, checked = 0, cyc = 0, n;
   int pos[11] = '{31, 30, 29, 28, 27, 26, 23, 22, 21, 20, 19};
   // Fan the model's grouped lines out to the design pins
   assign {bus_reset, unified_write_done, transfer_done} = pipe_events;
   assign {rx_full, rx_almost_full, rx_four_stored, rx_packet_edge_flag, rx_one_stored, rx_empty,
      tx_full, tx_room_one, tx_room_four, tx_one_left, tx_empty} = fifo_flags;
   pipe_status_retry #(.TICK_CYCLES(4)) i_pipe_status_retry (.*);
   pipe_remote_model u_remote (.*);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One APB transfer; holds until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   task automatic wait_for(input logic which, input int lim);
      n = 0;
      while ((which ? pipe_fault_interrupt : retransmit) !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   // Start, one request, optional response, then status
   task automatic fault_case(input logic dir, input logic [3:0] ack, input logic rsp, input logic [3:0] rc, tc,
      input logic src, input logic [3:0] ao, input logic [31:0] e);
      pipe_direction <= dir;
      apb(1'b1, 8'h34, 32'h1);
      rd(8'h38, 32'h0);
      u_remote.ack_req(ack);
      if (rsp) u_remote.respond(2, rc, tc, src, ao);
      repeat (3) @(posedge pclk);
      rd(8'h38, e);
      `CHK(pipe_active, 1'b0)
   endtask
   initial begin
      {presetn, psel, penable, pwrite, pipe_direction, paddr, pwdata} <= '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h38, 32'h0);
      rd(8'h3C, 32'h00000320);
      rd(8'h40, 32'h04280000);
      apb(1'b1, 8'h38, 32'hFFFF);
      rd(8'h38, 32'h0);
      apb(1'b0, 8'h50, 32'h0);
      `CHK(err, 1'b1)
      $display("test reset done");
      for (int i = 0; i < 11; i++) begin
         u_remote.set_flags(11'h400 >> i);
         rd(8'h40, 32'h1 << pos[i]);
      end
      apb(1'b1, 8'h40, 32'hFFFFFFFE);
      rd(8'h40, 32'h00080000);
      apb(1'b1, 8'h40, 32'h1);
      apb(1'b1, 8'h40, 32'h80000001);
      rd(8'h40, 32'h80000001);
      apb(1'b1, 8'h40, 32'h0);
      rd(8'h40, 32'h00080000);
      $display("test fifo status done");
      fault_case(0, 4'hD, 0, 4'h0, 4'h0, 1, 4'h1, 32'h000010D0);
      fault_case(0, 4'h2, 1, 4'h0, 4'h6, 1, 4'hD, 32'h0000202D);
      fault_case(0, 4'h2, 1, 4'h4, 4'h6, 1, 4'h1, 32'h00006421);
      fault_case(0, 4'h2, 1, 4'h0, 4'h6, 0, 4'h1, 32'h00007021);
      fault_case(0, 4'h2, 1, 4'h0, 4'h2, 1, 4'h1, 32'h00008021);
      fault_case(1, 4'h2, 1, 4'h0, 4'h6, 1, 4'h1, 32'h00008021);
      fault_case(1, 4'h2, 1, 4'h0, 4'h7, 1, 4'h1, 32'h00008021);
      fault_case(0, 4'h2, 1, 4'h4, 4'h2, 0, 4'hD, 32'h0000242D);
      fault_case(0, 4'h4, 0, 4'h0, 4'h0, 1, 4'h1, 32'h00004040);
      apb(1'b1, 8'h34, 32'h1);
      u_remote.ack_req(4'h2);
      u_remote.pulse(3'b100);
      repeat (3) @(posedge pclk);
      rd(8'h38, 32'h00005020);
      apb(1'b1, 8'h34, 32'h4);
      rd(8'h38, 32'h0);
      u_remote.ack_req(4'hD);
      repeat (3) @(posedge pclk);
      rd(8'h38, 32'h0);
      apb(1'b1, 8'h34, 32'h1);
      u_remote.ack_req(4'h1);
      u_remote.pulse(3'b010);
      u_remote.pulse(3'b001);
      repeat (2) @(posedge pclk);
      rd(8'h38, 32'h00000F10);
      `CHK(pipe_active, 1'b0)
      $display("test faults done");
      apb(1'b1, 8'h3C, 32'h00120003);
      apb(1'b1, 8'h34, 32'h1);
      for (int k = 0; k < 2; k++) begin
         u_remote.ack_req(4'h4);
         wait_for(0, 30);
         `CHK(n > 1 && n < 12, 1'b1)
      end
      u_remote.ack_req(4'h4);
      repeat (3) @(posedge pclk);
      rd(8'h38, 32'h00004040);
      apb(1'b1, 8'h3C, 32'h00000003);
      apb(1'b1, 8'h34, 32'h1);
      u_remote.ack_req(4'h2);
      wait_for(1, 40);
      `CHK(n >= 8 && n <= 20, 1'b1)
      rd(8'h38, 32'h00003020);
      apb(1'b1, 8'h3C, 32'h00010003);
      apb(1'b1, 8'h34, 32'h1);
      u_remote.ack_req(4'h4);
      wait_for(0, 10);
      `CHK(n, 2)
      u_remote.ack_req(4'h1);
      u_remote.pulse(3'b001);
      repeat (2) @(posedge pclk);
      rd(8'h38, 32'h00000010);
      `CHK(pipe_active, 1'b0)
      $display("test retry done");
      test_done();
   end
endmodule
